// file: hw/qepc_encoder_position_unit.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
// Summary of operation
// - Config bit 0x4 selects step/dir, else quadrature
// - Quadrature direction follows phase edge order
// - Step/dir counts A steps, B level gives direction
// - Capture choice matters only in quadrature decoding
// - Single phase mode counts both A edges
// - Both phases mode counts each A or B edge that does not coincide with an edge on the other phase
// - Counter accumulates continuously without software help
// - Counter equal to wrap limit becomes zero
// - Index clear on: index pulse clears counter
// - Index clear off: index pulses are ignored
// - Swap bit exchanges phase A and B
// - Last direction reads as plus or minus one
// - Counting runs only between start and stop
module qepc_encoder_position_unit
    import qepc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        phase_a_in,
    input  wire logic        phase_b_in,
    input  wire logic        index_in,
    output logic      [31:0] position,
    output logic             direction_forward,
    output logic             counting_go
);

    qepc_cfg_t   cfg;
    logic [31:0] wrap_limit;
    logic        in_s1   [0:2];
    logic        in_s2   [0:2];
    logic        in_prev [0:2];
    logic        a_now;
    logic        a_old;
    logic        b_now;
    logic        b_old;
    logic        a_edge;
    logic        b_edge;
    logic        count_ev;
    logic        fwd;
    logic        idx_clr;
    logic        wr_en;
    logic        setup;
    logic        addr_ok;
    logic [31:0] rd_val;
    logic [31:0] next_position;
    logic [31:0] step_val;

    // Input synchroniser and edge history
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_s1[gi]   <= 1'b0;
                    in_s2[gi]   <= 1'b0;
                    in_prev[gi] <= 1'b0;
                end else begin
                    in_s1[gi]   <= (gi == 0) ? phase_a_in :
                                   (gi == 1) ? phase_b_in : index_in;
                    in_s2[gi]   <= in_s1[gi];
                    in_prev[gi] <= in_s2[gi];
                end
            end
        end
    endgenerate

    // Phase selection with optional swap
    always_comb begin
        a_now = cfg.swap ? in_s2[1] : in_s2[0];
        a_old = cfg.swap ? in_prev[1] : in_prev[0];
        b_now = cfg.swap ? in_s2[0] : in_s2[1];
        b_old = cfg.swap ? in_prev[0] : in_prev[1];
    end

    assign a_edge = a_now ^ a_old;
    assign b_edge = b_now ^ b_old;

    // Decoder: counting event and direction
    always_comb begin
        count_ev = 1'b0;
        fwd      = direction_forward;
        if (cfg.step_dir) begin
            count_ev = a_edge & a_now;
            fwd      = b_now;
        end else if (a_edge && !b_edge) begin
            count_ev = 1'b1;
            fwd      = a_now ^ b_now;
        end else if (b_edge && !a_edge) begin
            count_ev = cfg.count_both;
            fwd      = (a_now == b_now);
        end
    end

    assign idx_clr = cfg.index_clear & in_s2[2] & ~in_prev[2];

    // Next position with wrap handling
    always_comb begin
        step_val = fwd ? position + 32'h0000_0001
                       : position - 32'h0000_0001;
        if (!fwd && position == 32'h0000_0000 && wrap_limit != '0) begin
            step_val = wrap_limit - 32'h0000_0001;
        end
        next_position = position;
        if (idx_clr) begin
            next_position = QEPC_RST_POSITION;
        end else if (count_ev) begin
            if (step_val == wrap_limit) begin
                next_position = QEPC_RST_POSITION;
            end else begin
                next_position = step_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position <= QEPC_RST_POSITION;
        end else if (counting_go) begin
            position <= next_position;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_forward <= 1'b1;
        end else if (counting_go && count_ev) begin
            direction_forward <= fwd;
        end
    end

    // APB slave
    assign setup = psel & ~penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;
    assign addr_ok = (paddr == QEPC_OFF_CONFIG) ||
                     (paddr == QEPC_OFF_WRAP) ||
                     (paddr == QEPC_OFF_CONTROL) ||
                     (paddr == QEPC_OFF_POSITION) ||
                     (paddr == QEPC_OFF_DIRECTION);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            QEPC_OFF_CONFIG:    rd_val = {27'h0, cfg};
            QEPC_OFF_WRAP:      rd_val = wrap_limit;
            QEPC_OFF_CONTROL:   rd_val = {31'h0, counting_go};
            QEPC_OFF_POSITION:  rd_val = position;
            QEPC_OFF_DIRECTION: rd_val = direction_forward ?
                                         QEPC_DIR_FORWARD :
                                         QEPC_DIR_REVERSE;
            default:            rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= QEPC_RST_CFG;
        end else if (wr_en && paddr == QEPC_OFF_CONFIG) begin
            cfg <= qepc_cfg_t'({pwdata[QEPC_BIT_INDEX_CLR],
                                pwdata[QEPC_BIT_BOTH],
                                pwdata[QEPC_BIT_STEP_DIR],
                                pwdata[QEPC_BIT_SWAP], 1'b0});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_limit <= QEPC_RST_WRAP;
        end else if (wr_en && paddr == QEPC_OFF_WRAP) begin
            wrap_limit <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counting_go <= 1'b0;
        end else if (wr_en && paddr == QEPC_OFF_CONTROL) begin
            counting_go <= pwdata[QEPC_BIT_GO];
        end
    end

    // Checks
    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !counting_go |=> $stable(position))
        else $error("position moved while stopped");

    a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev && !idx_clr && step_val == wrap_limit
        |=> position == 32'h0000_0000)
        else $error("position did not wrap to zero");

    a_index_clear: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && cfg.index_clear && in_s2[2] && !in_prev[2]
        |=> position == 32'h0000_0000)
        else $error("index pulse did not clear position");

    a_index_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.index_clear && !count_ev |=> $stable(position))
        else $error("position changed without a counted edge");

    a_fwd_inc: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev && fwd && !idx_clr
        && position + 32'h0000_0001 != wrap_limit
        |=> position == $past(position) + 32'h0000_0001)
        else $error("forward edge did not increment");

    a_rev_dec: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev && !fwd && !idx_clr
        && position != 32'h0000_0000
        && position - 32'h0000_0001 != wrap_limit
        |=> position == $past(position) - 32'h0000_0001)
        else $error("reverse edge did not decrement");

    a_single_phase: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.step_dir && !cfg.count_both && !a_edge && !idx_clr
        |=> $stable(position))
        else $error("counted a B edge in single phase mode");

    a_step_fall: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.step_dir && !(a_edge && a_now) && !idx_clr
        |=> $stable(position))
        else $error("step mode counted without rising step");

    a_both_count: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && cfg.count_both && b_edge
        && !a_edge && !idx_clr && wrap_limit > 32'h0000_0002
        |=> !$stable(position))
        else $error("B edge not counted in both phases mode");

    a_dir_report: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev |=> direction_forward == $past(fwd))
        else $error("direction not remembered");

    a_sync_path: assert property (@(posedge pclk) disable iff (!presetn)
        in_s1[0] |=> in_s2[0] ##1 in_prev[0])
        else $error("synchroniser pipeline broken");

    a_sync_index: assert property (@(posedge pclk) disable iff (!presetn)
        in_s1[2] |=> in_s2[2])
        else $error("index synchroniser broken");

    a_stop_dir: assert property (@(posedge pclk) disable iff (!presetn)
        !counting_go |=> $stable(direction_forward))
        else $error("direction moved while stopped");

    a_step_dir: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && cfg.step_dir && count_ev
        |=> direction_forward == $past(b_now))
        else $error("step direction not taken from B level");

    a_quad_a_dir: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && a_edge && !b_edge
        |=> direction_forward == ($past(a_now) ^ $past(b_now)))
        else $error("wrong direction on A edge");

    a_quad_b_dir: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && cfg.count_both && b_edge && !a_edge
        |=> direction_forward == ($past(a_now) == $past(b_now)))
        else $error("wrong direction on B edge");

    a_same_edge: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.step_dir && a_edge && b_edge && !idx_clr |=> $stable(position))
        else $error("counted when both phases moved together");

    a_swap_route: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.swap |-> a_now == in_s2[1] && b_now == in_s2[0])
        else $error("phases not exchanged");

    a_straight: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.swap |-> a_now == in_s2[0] && b_now == in_s2[1])
        else $error("phases exchanged while straight");

    a_single_count: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && a_edge && !b_edge && !idx_clr
        && wrap_limit > 32'h0000_0002
        |=> !$stable(position))
        else $error("A edge not counted");

    a_step_rise: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && cfg.step_dir && a_edge && a_now && !idx_clr
        && wrap_limit > 32'h0000_0002
        |=> !$stable(position))
        else $error("rising step not counted");

    a_step_no_b: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.step_dir && b_edge && !a_edge && !idx_clr |=> $stable(position))
        else $error("direction pin change was counted");

    a_dec_zero: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev && !fwd && !idx_clr
        && position == 32'h0000_0000 && wrap_limit > 32'h0000_0001
        |=> position == $past(wrap_limit) - 32'h0000_0001)
        else $error("decrement from zero did not wrap");

    a_index_wins: assert property (@(posedge pclk) disable iff (!presetn)
        counting_go && idx_clr && count_ev |=> position == 32'h0000_0000)
        else $error("count beat index clear");

    a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == QEPC_OFF_CONFIG
        |=> cfg.step_dir == $past(pwdata[QEPC_BIT_STEP_DIR]))
        else $error("decoding mode not written");

    a_go_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == QEPC_OFF_CONTROL
        |=> counting_go == $past(pwdata[QEPC_BIT_GO]))
        else $error("start or stop not taken");

    c_quad_fwd: cover property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && count_ev && fwd);
    c_quad_rev: cover property (@(posedge pclk) disable iff (!presetn)
        counting_go && !cfg.step_dir && count_ev && !fwd);
    c_step_dir: cover property (@(posedge pclk) disable iff (!presetn)
        counting_go && cfg.step_dir && count_ev);
    c_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        counting_go && count_ev && step_val == wrap_limit);
    c_index: cover property (@(posedge pclk) disable iff (!presetn)
        counting_go && idx_clr);

endmodule

// file: hw/qepc_pkg.sv
package qepc_pkg;

    // Register byte offsets
    localparam logic [7:0] QEPC_OFF_CONFIG    = 8'h00;
    localparam logic [7:0] QEPC_OFF_WRAP      = 8'h04;
    localparam logic [7:0] QEPC_OFF_CONTROL   = 8'h08;
    localparam logic [7:0] QEPC_OFF_POSITION  = 8'h0C;
    localparam logic [7:0] QEPC_OFF_DIRECTION = 8'h10;

    // Configuration and control field positions
    localparam int QEPC_BIT_SWAP      = 1;
    localparam int QEPC_BIT_STEP_DIR  = 2;
    localparam int QEPC_BIT_BOTH      = 3;
    localparam int QEPC_BIT_INDEX_CLR = 4;
    localparam int QEPC_BIT_GO        = 0;

    // Configuration patterns
    localparam logic [31:0] QEPC_PHASES_STRAIGHT    = 32'h0000_0000;
    localparam logic [31:0] QEPC_PHASES_EXCHANGED   = 32'h0000_0002;
    localparam logic [31:0] QEPC_PHASE_PAIR_DECODE  = 32'h0000_0000;
    localparam logic [31:0] QEPC_STEP_DIR_DECODE    = 32'h0000_0004;
    localparam logic [31:0] QEPC_COUNT_SINGLE_PHASE = 32'h0000_0000;
    localparam logic [31:0] QEPC_COUNT_BOTH_PHASES  = 32'h0000_0008;
    localparam logic [31:0] QEPC_INDEX_CLEAR_OFF    = 32'h0000_0000;
    localparam logic [31:0] QEPC_INDEX_CLEAR_ON     = 32'h0000_0010;

    // Reset values and direction read codes
    localparam logic [31:0] QEPC_RST_WRAP     = 32'h0000_0000;
    localparam logic [31:0] QEPC_RST_POSITION = 32'h0000_0000;
    localparam logic [31:0] QEPC_DIR_FORWARD  = 32'h0000_0001;
    localparam logic [31:0] QEPC_DIR_REVERSE  = 32'hFFFF_FFFF;

    typedef struct packed {
        logic index_clear;
        logic count_both;
        logic step_dir;
        logic swap;
        logic unused0;
    } qepc_cfg_t;

    localparam qepc_cfg_t QEPC_RST_CFG = '0;

endpackage

// file: tb/qepc_encoder_model.sv
`timescale 1ns/1ns
module qepc_encoder_model (
    input  wire logic pclk,
    output logic      phase_a,
    output logic      phase_b,
    output logic      index
);
    int q = 0;
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        index = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Quarter steps; forward means A leads B
    task automatic quad(input bit fwd, input int n);
        repeat (n) begin
            @(posedge pclk);
            q = fwd ? (q + 1) % 4 : (q + 3) % 4;
            phase_a <= (q == 1 || q == 2);
            phase_b <= (q >= 2);
            hold(3);
        end
    endtask
    // Step pulses on one pin, direction level on the other
    task automatic step(input bit fwd, input bit swp, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (swp) phase_a <= fwd; else phase_b <= fwd;
            hold(3);
            if (swp) phase_b <= 1'b1; else phase_a <= 1'b1;
            hold(3);
            if (swp) phase_b <= 1'b0; else phase_a <= 1'b0;
            hold(3);
        end
        phase_a <= 1'b0;
        phase_b <= 1'b0;
        hold(3);
    endtask
    task automatic pulse;
        @(posedge pclk);
        index <= 1'b1;
        hold(3);
        index <= 1'b0;
        hold(3);
    endtask
endmodule

// file: tb/qepc_encoder_position_unit_tb_top.sv
`timescale 1ns/1ns
module qepc_encoder_position_unit_tb_top
    import qepc_pkg::*;
;
    typedef struct {
        logic [31:0] cfg;
        bit          stp;
        bit          fwd;
        int          n;
        int          delta;
        bit          dir;
    } qepc_row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pha;
    logic        phb;
    logic        idx;
    logic [31:0] position;
    logic        direction_forward;
    logic        counting_go;
    logic [31:0] rd;
    logic [31:0] expp = 32'h0;
    logic        err;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [31:0] rst_exp[5] = '{32'h0, QEPC_RST_WRAP, 32'h0,
                                QEPC_RST_POSITION, QEPC_DIR_FORWARD};
    qepc_row_t   rows[10] = '{
        '{QEPC_COUNT_SINGLE_PHASE, 0, 1, 4, 2, 1},
        '{QEPC_COUNT_SINGLE_PHASE, 0, 0, 4, -2, 0},
        '{QEPC_COUNT_BOTH_PHASES, 0, 1, 4, 4, 1},
        '{QEPC_COUNT_BOTH_PHASES, 0, 0, 4, -4, 0},
        '{QEPC_PHASES_EXCHANGED, 0, 1, 4, -2, 0},
        '{QEPC_PHASES_EXCHANGED | QEPC_COUNT_BOTH_PHASES, 0, 0, 4, 4, 1},
        '{QEPC_STEP_DIR_DECODE, 1, 1, 3, 3, 1},
        '{QEPC_STEP_DIR_DECODE, 1, 0, 3, -3, 0},
        '{QEPC_STEP_DIR_DECODE | QEPC_COUNT_BOTH_PHASES, 1, 1, 2, 2, 1},
        '{QEPC_STEP_DIR_DECODE | QEPC_PHASES_EXCHANGED, 1, 1, 2, 2, 1}};
    always #4 pclk = ~pclk;
    qepc_encoder_position_unit qepc_encoder_position_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_a_in(pha),
        .phase_b_in(phb), .index_in(idx), .position(position),
        .direction_forward(direction_forward), .counting_go(counting_go));
    qepc_encoder_model qepc_encoder_model_i (
        .pclk(pclk), .phase_a(pha), .phase_b(phb), .index(idx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("ERROR t=%0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdchk(8'(4 * i), rst_exp[i]);
        chk({31'h0, counting_go}, 32'h0);
        chk({31'h0, direction_forward}, 32'h1);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h14, 32'h0);
        apb(1'b1, QEPC_OFF_CONFIG, 32'hFFFF_FFFF);
        rdchk(QEPC_OFF_CONFIG, 32'h0000_001E);
        apb(1'b1, QEPC_OFF_POSITION, 32'h0000_0055);
        rdchk(QEPC_OFF_POSITION, 32'h0);
        apb(1'b1, QEPC_OFF_CONTROL, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, counting_go}, 32'h1);
        $display("reset and map test done");
        foreach (rows[i]) begin
            apb(1'b1, QEPC_OFF_CONFIG, rows[i].cfg);
            if (rows[i].stp)
                qepc_encoder_model_i.step(rows[i].fwd,
                    rows[i].cfg[QEPC_BIT_SWAP], rows[i].n);
            else
                qepc_encoder_model_i.quad(rows[i].fwd, rows[i].n);
            expp = expp + rows[i].delta;
            repeat (4) @(posedge pclk);
            rdchk(QEPC_OFF_POSITION, expp);
            rdchk(QEPC_OFF_DIRECTION, rows[i].dir ? QEPC_DIR_FORWARD
                                                  : QEPC_DIR_REVERSE);
            chk({31'h0, direction_forward}, {31'h0, rows[i].dir});
            chk(position, expp);
            $display("row %0d done", i);
        end
        apb(1'b1, QEPC_OFF_CONFIG, QEPC_COUNT_BOTH_PHASES);
        apb(1'b1, QEPC_OFF_CONTROL, 32'h0);
        qepc_encoder_model_i.quad(1'b1, 4);
        repeat (4) @(posedge pclk);
        rdchk(QEPC_OFF_POSITION, expp);
        apb(1'b1, QEPC_OFF_CONTROL, 32'h1);
        qepc_encoder_model_i.pulse();
        repeat (4) @(posedge pclk);
        rdchk(QEPC_OFF_POSITION, expp);
        apb(1'b1, QEPC_OFF_CONFIG,
            QEPC_COUNT_BOTH_PHASES | QEPC_INDEX_CLEAR_ON);
        qepc_encoder_model_i.pulse();
        repeat (4) @(posedge pclk);
        rdchk(QEPC_OFF_POSITION, 32'h0);
        apb(1'b1, QEPC_OFF_WRAP, 32'h3);
        rdchk(QEPC_OFF_WRAP, 32'h3);
        qepc_encoder_model_i.quad(1'b1, 4);
        repeat (4) @(posedge pclk);
        rdchk(QEPC_OFF_POSITION, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(position, QEPC_RST_POSITION);
        chk({31'h0, counting_go}, 32'h0);
        presetn <= 1'b1;
        rdchk(QEPC_OFF_WRAP, QEPC_RST_WRAP);
        rdchk(QEPC_OFF_CONFIG, 32'h0);
        $display("stop, index and wrap test done");
        results();
    end
endmodule
